//--- verilog/switch_node_pkg.sv
package switch_node_pkg;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] ADDR_IDENT   = 8'h00; // Node identification
  localparam logic [7:0] ADDR_DESC    = 8'h01; // Switch description
  localparam logic [7:0] ADDR_CONFIG  = 8'h04; // Switch configuration
  localparam logic [7:0] ADDR_NODE_ID = 8'h05; // Node identifier
  localparam logic [7:0] ADDR_PLL     = 8'h06; // PLL settings

  // ********************************************************
  // Field positions and writable masks
  // ********************************************************
  localparam int WRITE_LOCK_BIT = 31;     // Blocks all writes
  localparam int PLL_LOCK_BIT   = 8;      // Blocks PLL updates
  localparam int HDR_MODE_BIT   = 0;      // 1-byte headers
  localparam int OUTDIV_LSB     = 23;     // Output divider low bit
  localparam int MUL_LSB        = 8;      // Feedback multiplier low bit
  localparam int IDIV_LSB       = 0;      // Input divider low bit
  localparam int STRAP_LSB      = 16;     // Strap field in identity
  localparam logic [31:0] CONFIG_WMASK  = 32'h8000_0101;
  localparam logic [31:0] NODE_ID_WMASK = 32'h0000_ffff;
  localparam logic [31:0] PLL_WMASK     = 32'h039f_ff7f;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [31:0] CONFIG_RST  = 32'h0000_0000;
  localparam logic [31:0] NODE_ID_RST = 32'h0000_0000;
  localparam logic [31:0] PLL_RST     = 32'h0000_0000;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS   = 10;    // Switch clock period
  localparam int TILE_RST_NS     = 40;    // Least tile reset length
  localparam int TILE_RST_CYCLES =
    (TILE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********************************************************
  // Most significant differing bit of two identities
  // ********************************************************
  function automatic logic [3:0] first_mismatch(input logic [15:0] a,
                                                input logic [15:0] b);
    logic [15:0] diff;
    diff = a ^ b;
    first_mismatch = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (diff[i]) begin
        first_mismatch = 4'(i);
      end
    end
  endfunction

endpackage

//--- verilog/strap_capture.sv
`timescale 1ns/1ps
module strap_capture (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       bootStrapPinA,
  input  wire logic       bootStrapPinB,
  output logic [1:0]      strapBits,
  output logic            strapLoad
);

  // ********************************************************
  // Capture straps on the first edge after reset release
  // ********************************************************
  logic       capturedQ;   // Capture done
  logic       capturedD;
  logic [1:0] bitsQ;       // Held strap levels
  logic [1:0] bitsD;
  logic       loadQ;       // One-cycle load pulse
  logic       loadD;

  // Next values: straps taken once, never again until reset
  always_comb begin
    capturedD = 1'b1;
    bitsD     = bitsQ;
    loadD     = 1'b0;
    if (!capturedQ) begin
      bitsD = {bootStrapPinB, bootStrapPinA};
      loadD = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      capturedQ <= 1'b0;
      bitsQ     <= 2'h0;
      loadQ     <= 1'b0;
    end else begin
      capturedQ <= capturedD;
      bitsQ     <= bitsD;
      loadQ     <= loadD;
    end
  end

  assign strapBits = bitsQ;
  assign strapLoad = loadQ;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_strap_single_load: assert property ( // RULE_12
    strapLoad |=> !strapLoad [*3])
    else $error("Strap load pulsed more than once");

endmodule

//--- verilog/route_compare.sv
`timescale 1ns/1ps
module route_compare (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] nodeId,
  input  wire logic [15:0] destId,
  input  wire logic        destValid,
  output logic             routeValid,
  output logic             routeMatch,
  output logic [3:0]       mismatchBit
);

  // ********************************************************
  // Destination compare, most significant bit first
  // ********************************************************
  logic       validQ;      // Result valid
  logic       validD;
  logic       matchQ;      // Destination is this node
  logic       matchD;
  logic [3:0] bitQ;        // Most significant differing bit
  logic [3:0] bitD;

  // Next values
  always_comb begin
    validD = destValid;
    matchD = matchQ;
    bitD   = bitQ;
    if (destValid) begin
      matchD = (destId == nodeId);
      bitD   = switch_node_pkg::first_mismatch(destId, nodeId); // RULE_09
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      validQ <= 1'b0;
      matchQ <= 1'b0;
      bitQ   <= 4'h0;
    end else begin
      validQ <= validD;
      matchQ <= matchD;
      bitQ   <= bitD;
    end
  end

  assign routeValid  = validQ;
  assign routeMatch  = matchQ;
  assign mismatchBit = bitQ;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_route_msb_first: assert property ( // RULE_09
    destValid && (destId != nodeId) |=> routeValid && !routeMatch &&
      (($past(destId ^ nodeId) & (16'h0001 << mismatchBit)) != 16'h0) &&
      (($past(destId ^ nodeId) >> mismatchBit) == 16'h0001))
    else $error("Route compare did not pick top differing bit");

  c_route_hit: cover property (destValid ##1 routeMatch);

endmodule

//--- verilog/switch_node_config_regs.sv
`timescale 1ns/1ps
// Operation
// RULE_01: Registers reached only by config reads, writes
// RULE_02: Identity: chip, straps, revision, version fields
// RULE_03: Read-only description: links, cores, links/processor
// RULE_04: Config bit 31 rejects all writes
// RULE_05: Config bit 8 blocks PLL updates
// RULE_06: Config bit 0 selects 1-byte headers
// RULE_07: Configurer sets same header mode everywhere
// RULE_08: Writable 16-bit node identity, reset zero
// RULE_09: Identity compared with destination, MSB first
// RULE_10: Accepted PLL write resets the tile
// RULE_11: PLL fields: output, feedback, input dividers
// RULE_12: PLL fields load from strap pins at reset
// RULE_13: Reserved bits read zero, ignore writes
module switch_node_config_regs #(
  parameter logic [7:0]  CHIP_ID      = 8'h5a, // Arbitrary value
  parameter logic [7:0]  SW_REVISION  = 8'h01, // Arbitrary value
  parameter logic [7:0]  SW_VERSION   = 8'h01, // Arbitrary value
  parameter logic [7:0]  LINK_COUNT   = 8'h08,
  parameter logic [7:0]  CORE_COUNT   = 8'h01,
  parameter logic [7:0]  LINKS_PER_PR = 8'h04,
  parameter logic [31:0] PLL_STRAP_0  = 32'h0080_1300,
  parameter logic [31:0] PLL_STRAP_1  = 32'h0080_1f00,
  parameter logic [31:0] PLL_STRAP_2  = 32'h0100_2700,
  parameter logic [31:0] PLL_STRAP_3  = 32'h0100_3100
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        bootStrapPinA,
  input  wire logic        bootStrapPinB,
  input  wire logic        cfgReq,
  input  wire logic        cfgWrite,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [31:0] cfgWdata,
  output logic             cfgAck,
  output logic             cfgRefused,
  output logic [31:0]      cfgRdata,
  input  wire logic [15:0] destId,
  input  wire logic        destValid,
  output logic             routeValid,
  output logic             routeMatch,
  output logic [3:0]       mismatchBit,
  output logic             headerOneByte,
  output logic [15:0]      nodeIdentity,
  output logic [2:0]       pllOutputDivider,
  output logic [12:0]      pllFeedbackMul,
  output logic [6:0]       pllInputDivider,
  output logic             tileReset
);

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [1:0]  strapBits;     // Captured strap levels
  logic        strapLoad;     // Load PLL from straps
  logic [31:0] configQ;       // Switch configuration
  logic [31:0] configD;
  logic [31:0] nodeIdQ;       // Node identifier
  logic [31:0] nodeIdD;
  logic [31:0] pllQ;          // PLL settings
  logic [31:0] pllD;
  logic        ackQ;          // Answer strobe
  logic        ackD;
  logic        refusedQ;      // Access refused
  logic        refusedD;
  logic [31:0] rdataQ;        // Read data
  logic [31:0] rdataD;
  logic [2:0]  tileCntQ;      // Tile reset remaining cycles
  logic [2:0]  tileCntD;
  logic        mapped;        // Address hits a register
  logic        writeLocked;   // All writes blocked
  logic        pllLocked;     // PLL writes blocked
  logic        wrAccept;      // Write will take effect, except to a locked PLL
  logic        pllAccept;     // PLL write accepted
  logic [31:0] readMux;       // Selected read value

  // ********************************************************
  // Strap capture and route compare
  // ********************************************************
  strap_capture u_strap (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .bootStrapPinA (bootStrapPinA),
    .bootStrapPinB (bootStrapPinB),
    .strapBits     (strapBits),
    .strapLoad     (strapLoad)
  );

  route_compare u_route (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .nodeId      (nodeIdQ[15:0]),
    .destId      (destId),
    .destValid   (destValid),
    .routeValid  (routeValid),
    .routeMatch  (routeMatch),
    .mismatchBit (mismatchBit)
  );

  // ********************************************************
  // Access decode
  // ********************************************************
  // PLL defaults chosen by the two strap levels
  function automatic logic [31:0] strap_pll(input logic [1:0] s);
    case (s)
      2'h0:    strap_pll = PLL_STRAP_0;
      2'h1:    strap_pll = PLL_STRAP_1;
      2'h2:    strap_pll = PLL_STRAP_2;
      default: strap_pll = PLL_STRAP_3;
    endcase
  endfunction

  // Address decode, locks and read selection
  always_comb begin
    writeLocked = configQ[switch_node_pkg::WRITE_LOCK_BIT];
    pllLocked   = configQ[switch_node_pkg::PLL_LOCK_BIT];
    mapped      = 1'b1;
    readMux     = 32'h0000_0000;
    case (cfgAddr)
      switch_node_pkg::ADDR_IDENT: begin
        readMux = {CHIP_ID, 6'h00, strapBits,               // RULE_02
                   SW_REVISION, SW_VERSION};
      end
      switch_node_pkg::ADDR_DESC: begin
        readMux = {8'h00, LINK_COUNT, CORE_COUNT, LINKS_PER_PR}; // RULE_03
      end
      switch_node_pkg::ADDR_CONFIG: begin
        readMux = configQ;
      end
      switch_node_pkg::ADDR_NODE_ID: begin
        readMux = nodeIdQ;
      end
      switch_node_pkg::ADDR_PLL: begin
        readMux = pllQ;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    // Read-only targets and locked switch refuse writes
    wrAccept = cfgReq && cfgWrite && mapped && !writeLocked && // RULE_04
               (cfgAddr != switch_node_pkg::ADDR_IDENT) &&
               (cfgAddr != switch_node_pkg::ADDR_DESC);
    pllAccept = wrAccept && (cfgAddr == switch_node_pkg::ADDR_PLL) &&
                !pllLocked;                                  // RULE_05
  end

  // ********************************************************
  // Register file
  // ********************************************************
  // Next register values and transaction answer
  always_comb begin
    configD  = configQ;
    nodeIdD  = nodeIdQ;
    pllD     = pllQ;
    ackD     = cfgReq;                                       // RULE_01
    rdataD   = 32'h0000_0000;
    refusedD = 1'b0;
    tileCntD = (tileCntQ != 3'h0) ? tileCntQ - 3'h1 : 3'h0;
    if (strapLoad) begin
      pllD = strap_pll(strapBits) & switch_node_pkg::PLL_WMASK; // RULE_12
    end
    if (cfgReq && !cfgWrite) begin
      rdataD   = readMux;
      refusedD = !mapped;
    end
    if (cfgReq && cfgWrite) begin
      refusedD = !wrAccept ||
                 ((cfgAddr == switch_node_pkg::ADDR_PLL) && !pllAccept);
    end
    if (wrAccept) begin
      case (cfgAddr)
        switch_node_pkg::ADDR_CONFIG: begin
          configD = cfgWdata & switch_node_pkg::CONFIG_WMASK; // RULE_13
        end
        switch_node_pkg::ADDR_NODE_ID: begin
          nodeIdD = cfgWdata & switch_node_pkg::NODE_ID_WMASK; // RULE_08
        end
        default: begin
          // PLL handled below, others are read-only
        end
      endcase
    end
    if (pllAccept) begin
      pllD     = cfgWdata & switch_node_pkg::PLL_WMASK;      // RULE_11
      tileCntD = 3'(switch_node_pkg::TILE_RST_CYCLES);       // RULE_10
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      configQ  <= switch_node_pkg::CONFIG_RST;
      nodeIdQ  <= switch_node_pkg::NODE_ID_RST;
      pllQ     <= switch_node_pkg::PLL_RST;
      ackQ     <= 1'b0;
      refusedQ <= 1'b0;
      rdataQ   <= 32'h0000_0000;
      tileCntQ <= 3'h0;
    end else begin
      configQ  <= configD;
      nodeIdQ  <= nodeIdD;
      pllQ     <= pllD;
      ackQ     <= ackD;
      refusedQ <= refusedD;
      rdataQ   <= rdataD;
      tileCntQ <= tileCntD;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign cfgAck           = ackQ;
  assign cfgRefused       = refusedQ;
  assign cfgRdata         = rdataQ;
  assign headerOneByte    = configQ[switch_node_pkg::HDR_MODE_BIT]; // RULE_06
  assign nodeIdentity     = nodeIdQ[15:0];
  assign pllOutputDivider = pllQ[switch_node_pkg::OUTDIV_LSB +: 3];
  assign pllFeedbackMul   = pllQ[switch_node_pkg::MUL_LSB +: 13];
  assign pllInputDivider  = pllQ[switch_node_pkg::IDIV_LSB +: 7];
  assign tileReset        = (tileCntQ != 3'h0);

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_answer_one_cycle: assert property ( // RULE_01
    cfgReq |=> cfgAck ##0 (cfgAck == $past(cfgReq)))
    else $error("Transaction not answered next cycle");

  a_ident_read: assert property ( // RULE_02
    cfgReq && !cfgWrite && cfgAddr == switch_node_pkg::ADDR_IDENT |=>
      cfgRdata == {CHIP_ID, 6'h00, $past(strapBits),
                   SW_REVISION, SW_VERSION})
    else $error("Identity read value wrong");

  a_desc_readonly: assert property ( // RULE_03
    cfgReq && cfgWrite && cfgAddr == switch_node_pkg::ADDR_DESC |=>
      cfgRefused)
    else $error("Write to description not refused");

  a_lock_all_writes: assert property ( // RULE_04
    cfgReq && cfgWrite && writeLocked |=>
      cfgRefused && $stable(configQ) && $stable(nodeIdQ) &&
      $stable(pllQ))
    else $error("Locked switch accepted a write");

  a_pll_lock: assert property ( // RULE_05
    cfgReq && cfgWrite && pllLocked && !strapLoad &&
    cfgAddr == switch_node_pkg::ADDR_PLL |=>
      cfgRefused && $stable(pllQ) &&
      (tileCntQ == 3'h0 || tileCntQ < $past(tileCntQ)))
    else $error("Locked PLL settings changed");

  a_header_mode: assert property ( // RULE_06
    wrAccept && cfgAddr == switch_node_pkg::ADDR_CONFIG |=>
      headerOneByte == $past(cfgWdata[0]))
    else $error("Header mode not taken from write");

  a_node_id_write: assert property ( // RULE_08
    wrAccept && cfgAddr == switch_node_pkg::ADDR_NODE_ID |=>
      nodeIdentity == $past(cfgWdata[15:0]) && nodeIdQ[31:16] == 16'h0)
    else $error("Node identity write wrong");

  a_tile_reset_len: assert property ( // RULE_10
    pllAccept |=> tileReset [*4])
    else $error("Tile reset shorter than four cycles");

  a_pll_fields: assert property ( // RULE_11
    pllAccept |=> pllFeedbackMul == $past(cfgWdata[20:8]) &&
      pllOutputDivider == $past(cfgWdata[25:23]) &&
      pllInputDivider == $past(cfgWdata[6:0]))
    else $error("PLL fields not written");

  a_pll_strap: assert property ( // RULE_12
    strapLoad && !pllAccept |=> pllQ ==
      (strap_pll($past(strapBits)) & switch_node_pkg::PLL_WMASK))
    else $error("PLL not loaded from straps");

  a_reserved_zero: assert property ( // RULE_13
    cfgAck |-> (configQ & ~switch_node_pkg::CONFIG_WMASK) == 32'h0 &&
      (nodeIdQ & ~switch_node_pkg::NODE_ID_WMASK) == 32'h0 &&
      (pllQ & ~switch_node_pkg::PLL_WMASK) == 32'h0)
    else $error("Reserved bits set");

  // Unmapped reads answer refused with zero data
  a_unmapped_read: assert property ( // RULE_01
    cfgReq && !cfgWrite && !mapped |=>
      cfgAck && cfgRefused && cfgRdata == 32'h0)
    else $error("Unmapped read not refused");

  // No answer strobe without a request before it
  a_ack_needs_req: assert property ( // RULE_01
    !cfgReq |=> !cfgAck && !cfgRefused)
    else $error("Answer without a request");

  c_pll_write:   cover property (pllAccept ##1 tileReset);
  c_lock_write:  cover property (cfgReq && cfgWrite && writeLocked);
  c_hdr_mode:    cover property ($rose(headerOneByte));
  c_unmapped:    cover property (cfgReq && !mapped ##1 cfgRefused);

endmodule

//--- dv/cfg_source.sv
`timescale 1ns/1ps
// ********************************************************
// Configuration transaction source on the interconnect
// ********************************************************
module cfg_source (
  input  wire logic        core_clk,
  output logic             cfgReq,
  output logic             cfgWrite,
  output logic [7:0]       cfgAddr,
  output logic [31:0]      cfgWdata,
  input  wire logic        cfgAck,
  input  wire logic        cfgRefused,
  input  wire logic [31:0] cfgRdata
);
  // Idle bus at time zero
  initial begin
    cfgReq = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 8'h00;
    cfgWdata = 32'h0000_0000;
  end

  // One read or write; answered low when no answer came
  task automatic transact(input logic wr, input logic [7:0] addr,
                          input logic [31:0] wd, output logic [31:0] rd,
                          output logic refused, output logic answered);
    int n;
    answered = 1'b0;
    rd = 32'h0000_0000;
    refused = 1'b0;
    @(posedge core_clk);
    cfgReq <= 1'b1;
    cfgWrite <= wr;
    cfgAddr <= addr;
    cfgWdata <= wd;
    @(posedge core_clk);
    // Request taken; qualifiers no longer hold their value
    cfgReq <= 1'b0;
    cfgWrite <= ~wr;
    cfgAddr <= ~addr;
    cfgWdata <= ~wd;
    for (n = 0; n < 4 && !answered; n++) begin
      @(posedge core_clk);
      // Answer stands for one cycle only
      if (cfgAck === 1'b1) begin
        answered = 1'b1;
        rd = cfgRdata;
        refused = cfgRefused;
      end
    end
  endtask
endmodule

//--- dv/test_switch_node_config_regs.sv
`timescale 1ns/1ps
module test_switch_node_config_regs;
  // ********************************************************
  // Constants, signals and stimulus rows
  // ********************************************************
  localparam logic [7:0]  CHIP = 8'h3c;         // Arbitrary value
  localparam logic [7:0]  REV  = 8'h02;         // Arbitrary value
  localparam logic [7:0]  VER  = 8'h07;         // Arbitrary value
  localparam logic [31:0] PS0  = 32'h0080_1300; // Straps both low
  localparam logic [31:0] PS3  = 32'h0100_3100; // Straps both high
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic        rf;
  } row_t;
  logic core_clk, rstn, pinA, pinB, cfgReq, cfgWrite, cfgAck, cfgRefused;
  logic [7:0]  cfgAddr;
  logic [31:0] cfgWdata, cfgRdata;
  logic [15:0] destId, nodeIdentity;
  logic destValid, routeValid, routeMatch, headerOneByte, tileReset;
  logic [3:0]  mismatchBit;
  logic [2:0]  pllOutputDivider;
  logic [12:0] pllFeedbackMul;
  logic [6:0]  pllInputDivider;
  row_t rows [25];
  int   failCount = 0;
  int   samplesChecked = 0;
  int   n;

  // ********************************************************
  // Design and far side
  // ********************************************************
  switch_node_config_regs #(.CHIP_ID(CHIP), .SW_REVISION(REV),
    .SW_VERSION(VER), .LINK_COUNT(8'h08), .CORE_COUNT(8'h02),
    .LINKS_PER_PR(8'h04), .PLL_STRAP_0(PS0), .PLL_STRAP_3(PS3)) DUT (
    .core_clk(core_clk), .rstn(rstn), .bootStrapPinA(pinA),
    .bootStrapPinB(pinB), .cfgReq(cfgReq), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgAck(cfgAck),
    .cfgRefused(cfgRefused), .cfgRdata(cfgRdata), .destId(destId),
    .destValid(destValid), .routeValid(routeValid),
    .routeMatch(routeMatch), .mismatchBit(mismatchBit),
    .headerOneByte(headerOneByte), .nodeIdentity(nodeIdentity),
    .pllOutputDivider(pllOutputDivider), .pllFeedbackMul(pllFeedbackMul),
    .pllInputDivider(pllInputDivider), .tileReset(tileReset));
  cfg_source host (.core_clk(core_clk), .cfgReq(cfgReq),
    .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata),
    .cfgAck(cfgAck), .cfgRefused(cfgRefused), .cfgRdata(cfgRdata));

  // Clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ********************************************************
  // Helper tasks
  // ********************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic giveVerdict();
    if (failCount == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Transaction with read data checked on reads only
  task automatic xfer(input row_t r);
    logic [31:0] rd;
    logic rf, ok;
    host.transact(r.wr, r.addr, r.wd, rd, rf, ok);
    // A missing answer counts as a mismatch; the run goes on
    if (!ok) begin
      failCount++;
    end else begin
      check(32'(rf), 32'(r.rf));
      if (!r.wr) begin
        check(rd, r.rd);
      end
    end
  endtask

  // Reset for 16 cycles with given strap levels
  task automatic doReset(input logic a, input logic b);
    @(posedge core_clk);
    rstn <= 1'b0;
    pinA <= a;
    pinB <= b;
    repeat (16) @(posedge core_clk);
    // Outputs held at their reset values
    check(32'({headerOneByte, nodeIdentity, tileReset, cfgAck}),
          32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // Count cycles of tile reset, starting in the answer cycle
  task automatic countTile(input int cycles);
    n = (tileReset === 1'b1) ? 1 : 0;
    repeat (cycles) begin
      @(posedge core_clk);
      if (tileReset === 1'b1) n++;
    end
  endtask

  // One destination compare, result in the following cycle
  task automatic route(input logic [15:0] d, input logic m,
                       input logic [3:0] b);
    @(posedge core_clk);
    destValid <= 1'b1;
    destId <= d;
    @(posedge core_clk);
    destValid <= 1'b0;
    destId <= ~d;
    @(posedge core_clk);
    check(32'({routeValid, routeMatch, mismatchBit}),
          32'({1'b1, m, b}));
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    rstn = 1'b0;
    pinA = 1'b1;
    pinB = 1'b1;
    destId = 16'h0000;
    destValid = 1'b0;
    rows = '{
      '{1'b0, 8'h00, 32'h0, {CHIP, 8'h03, REV, VER}, 1'b0},
      '{1'b0, 8'h01, 32'h0, 32'h0008_0204, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h05, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h06, 32'h0, PS3, 1'b0},
      '{1'b1, 8'h00, 32'hffff_ffff, 32'h0, 1'b1},
      '{1'b1, 8'h01, 32'hffff_ffff, 32'h0, 1'b1},
      '{1'b0, 8'h02, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h03, 32'hffff_ffff, 32'h0, 1'b1},
      '{1'b1, 8'h05, 32'hffff_1234, 32'h0, 1'b0},
      '{1'b0, 8'h05, 32'h0, 32'h0000_1234, 1'b0},
      '{1'b1, 8'h06, 32'hffff_ffff, 32'h0, 1'b0},
      '{1'b0, 8'h06, 32'h0, 32'h039f_ff7f, 1'b0},
      '{1'b1, 8'h04, 32'h0000_0001, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h0000_0001, 1'b0},
      '{1'b1, 8'h04, 32'h7fff_ffff, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h0000_0101, 1'b0},
      '{1'b1, 8'h06, 32'h0, 32'h0, 1'b1},
      '{1'b0, 8'h06, 32'h0, 32'h039f_ff7f, 1'b0},
      '{1'b1, 8'h05, 32'h0000_abcd, 32'h0, 1'b0},
      '{1'b1, 8'h04, 32'h8000_0101, 32'h0, 1'b0},
      '{1'b1, 8'h05, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h04, 32'h0, 32'h0, 1'b1},
      '{1'b0, 8'h05, 32'h0, 32'h0000_abcd, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h8000_0101, 1'b0}};
    doReset(1'b1, 1'b1);
    // Table of ordinary accesses
    for (int i = 0; i < 25; i++) begin
      xfer(rows[i]);
    end
    check(32'({headerOneByte, nodeIdentity}), 32'h0001_abcd);
    check(32'({pllOutputDivider, pllFeedbackMul, pllInputDivider}),
          32'h007f_ffff);
    // Second reset with other straps clears both locks
    doReset(1'b0, 1'b0);
    xfer('{1'b0, 8'h00, 32'h0, {CHIP, 8'h00, REV, VER}, 1'b0});
    xfer('{1'b0, 8'h04, 32'h0, 32'h0, 1'b0});
    xfer('{1'b0, 8'h06, 32'h0, PS0, 1'b0});
    check(32'({pllOutputDivider, pllFeedbackMul, pllInputDivider}),
          32'({PS0[25:23], PS0[20:8], PS0[6:0]}));
    // Accepted PLL write pulses tile reset for four cycles
    xfer('{1'b1, 8'h06, PS3, 32'h0, 1'b0});
    countTile(7);
    check(32'(n), 32'd4);
    // Routing compare, most significant mismatch first
    xfer('{1'b1, 8'h05, 32'h0000_8001, 32'h0, 1'b0});
    route(16'h8001, 1'b1, 4'h0);
    route(16'h0001, 1'b0, 4'hf);
    route(16'h8003, 1'b0, 4'h1);
    route(16'h7ffe, 1'b0, 4'hf);
    // Blocked PLL write leaves fields and tile alone
    // Lock PLL, header set to one byte as on every other node
    xfer('{1'b1, 8'h04, 32'h0000_0101, 32'h0, 1'b0});
    check(32'(headerOneByte), 32'h1);
    xfer('{1'b1, 8'h06, 32'h0, 32'h0, 1'b1});
    countTile(6);
    check(32'(n), 32'd0);
    check(32'({pllOutputDivider, pllFeedbackMul, pllInputDivider}),
          32'({PS3[25:23], PS3[20:8], PS3[6:0]}));
    giveVerdict();
  end
endmodule
